// ===== utd_termination_decode.sv
// USB termination decode: Avalon-MM register file holding the transceiver fields
// and the decode that turns them into the four data-line resistor enables.
// Assumes the Avalon master holds each request until waitrequest is sampled low.
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps

module utd_termination_decode (
    // Clock and reset.
    input  wire logic              CLK_I,
    input  wire logic              RSTN_I,
    // Avalon-MM slave.
    input  wire logic [3:0]        AVS_ADDRESS_I,
    input  wire logic              AVS_READ_I,
    input  wire logic              AVS_WRITE_I,
    input  wire logic [3:0]        AVS_BYTEENABLE_I,
    input  wire utd_pkg::utd_word_t AVS_WRITEDATA_I,
    output utd_pkg::utd_word_t     AVS_READDATA_O,
    output logic                   AVS_WAITREQUEST_O,
    // Resistor enables toward the analog front end.
    output logic                   DPLUS_PULLUP_ENABLE_O,
    output logic                   DPLUS_PULLDOWN_ENABLE_O,
    output logic                   DMINUS_PULLDOWN_ENABLE_O,
    output logic                   HIGHSPEED_TERMINATION_ENABLE_O
);
    import utd_pkg::*;

    logic [UTD_CTRL_W-1:0] ctrl_ff;
    logic [3:0]            en_ff;
    logic                  ack_ff;
    utd_word_t             rdata_ff;

    wire       req         = AVS_READ_I | AVS_WRITE_I;
    wire       hit_ctrl    = AVS_ADDRESS_I == UTD_CTRL_OFS;
    wire       hit_status  = AVS_ADDRESS_I == UTD_STATUS_OFS;
    wire       ctrl_wr     = AVS_WRITE_I & ack_ff & hit_ctrl & AVS_BYTEENABLE_I[0];
    wire       rd_sample   = AVS_READ_I & ~ack_ff;

    // Field views of the control register.
    wire [1:0] transceiver_speed_select = ctrl_ff[UTD_SPEED_LSB +: 2];
    wire       termination_select       = ctrl_ff[UTD_TERM_BIT];
    wire [1:0] operating_mode_field     = ctrl_ff[UTD_MODE_LSB +: 2];
    wire       dplus_pulldown_ctl       = ctrl_ff[UTD_DPPD_BIT];
    wire       dminus_pulldown_ctl      = ctrl_ff[UTD_DMPD_BIT];

    // Decode. The pull-downs follow their controls, the high-speed termination is
    // on when the HS transceiver runs without FS termination, and the pull-up is
    // on for an FS-terminated port that is not set to low speed and is not pulling D+ down itself.
    wire       drivers_off = operating_mode_field == UTD_MODE_NODRV;
    wire       pu_dec      = termination_select & ~dplus_pulldown_ctl
                             & (transceiver_speed_select != UTD_SPEED_LS);
    wire       hst_dec     = ~termination_select
                             & (transceiver_speed_select == UTD_SPEED_HS);
    wire [3:0] dec_en      = {pu_dec, dplus_pulldown_ctl, dminus_pulldown_ctl,
                              hst_dec};
    wire [3:0] nxt_en      = drivers_off ? UTD_EN_OFF : dec_en;

    wire [UTD_CTRL_W-1:0] nxt_ctrl = ctrl_wr ? AVS_WRITEDATA_I[UTD_CTRL_W-1:0] : ctrl_ff;

    // Read mux; unmapped addresses read as zero.
    wire utd_word_t rd_mux = hit_ctrl   ? {{(32-UTD_CTRL_W){1'b0}}, ctrl_ff} :
                             hit_status ? {28'h0000000, en_ff} : 32'h00000000;
    wire utd_word_t nxt_rdata = rd_sample ? rd_mux : rdata_ff;

    // One wait state on every access: the answer comes on the second cycle.
    assign AVS_WAITREQUEST_O = req & ~ack_ff;
    assign AVS_READDATA_O    = rdata_ff;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            ack_ff   <= req & ~ack_ff;
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_ff <= UTD_CTRL_RST;
            en_ff   <= UTD_EN_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
            en_ff   <= nxt_en;
        end
    end

    assign DPLUS_PULLUP_ENABLE_O          = en_ff[UTD_EN_PU];
    assign DPLUS_PULLDOWN_ENABLE_O        = en_ff[UTD_EN_DPPD];
    assign DMINUS_PULLDOWN_ENABLE_O       = en_ff[UTD_EN_DMPD];
    assign HIGHSPEED_TERMINATION_ENABLE_O = en_ff[UTD_EN_HST];

    // Checks. Every property samples on the rising clock edge and sleeps during reset.
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    wire [3:0] en_out = {DPLUS_PULLUP_ENABLE_O, DPLUS_PULLDOWN_ENABLE_O,
                         DMINUS_PULLDOWN_ENABLE_O, HIGHSPEED_TERMINATION_ENABLE_O};

    // Matches a control value against one row of the signaling-state table.
    // The control value is an argument so that the checks see its sampled value.
    function automatic logic fld(input logic [UTD_CTRL_W-1:0] c,
                                 input logic [1:0]            sp,
                                 input logic                  tm,
                                 input logic [1:0]            md,
                                 input logic                  dp,
                                 input logic                  dm);
        fld = c[UTD_SPEED_LSB +: 2] == sp
              && c[UTD_TERM_BIT] == tm
              && c[UTD_MODE_LSB +: 2] == md
              && c[UTD_DPPD_BIT] == dp
              && c[UTD_DMPD_BIT] == dm;
    endfunction

    // Bus steps: the first cycle of a request waits, the second one is answered.
    sequence s_req_wait;
        req && AVS_WAITREQUEST_O;
    endsequence

    sequence s_req_done;
        req && !AVS_WAITREQUEST_O;
    endsequence

    sequence s_ctrl_store;
        s_req_done and (AVS_WRITE_I && hit_ctrl && AVS_BYTEENABLE_I[0]);
    endsequence

    sequence s_status_read;
        (s_req_wait and (AVS_READ_I && hit_status)) ##1 s_req_done;
    endsequence

    sequence s_ctrl_read;
        (s_req_wait and (AVS_READ_I && hit_ctrl)) ##1 s_req_done;
    endsequence

    sequence s_void_read;
        (s_req_wait and (AVS_READ_I && !hit_ctrl && !hit_status)) ##1 s_req_done;
    endsequence

    // Register bus.
    a_bus_one_wait: assert property (
        s_req_wait ##1 req
        |-> !AVS_WAITREQUEST_O)
        else $error("Access not answered after one wait state.");

    a_wait_first: assert property (
        req && !ack_ff
        |-> AVS_WAITREQUEST_O)
        else $error("First cycle of a request not held off.");

    a_ack_single: assert property (
        ack_ff
        |=> !ack_ff)
        else $error("Answer stretched over two cycles.");

    a_ctrl_write: assert property (
        s_ctrl_store
        |=> ctrl_ff == $past(AVS_WRITEDATA_I[UTD_CTRL_W-1:0]))
        else $error("Control write not stored.");

    a_ctrl_hold: assert property (
        !ctrl_wr
        |=> $stable(ctrl_ff))
        else $error("Control changed without an answered write.");

    a_refused_write: assert property (
        AVS_WRITE_I && !(hit_ctrl && AVS_BYTEENABLE_I[0])
        |=> $stable(ctrl_ff))
        else $error("Refused write changed the control fields.");

    a_status_read: assert property (
        s_status_read
        |-> AVS_READDATA_O == {28'h0000000, $past(en_ff)})
        else $error("Status read does not show the enables.");

    a_ctrl_read: assert property (
        s_ctrl_read
        |-> AVS_READDATA_O == {25'h0000000, $past(ctrl_ff)})
        else $error("Control read does not show the fields.");

    a_void_read: assert property (
        s_void_read
        |-> AVS_READDATA_O == 32'h00000000)
        else $error("Unmapped read not zero.");

    a_rdata_hold: assert property (
        !rd_sample
        |=> $stable(AVS_READDATA_O))
        else $error("Read data moved outside a read.");

    // Resistor enables in general.
    a_mode_tristate: assert property (
        drivers_off
        |=> en_out == UTD_EN_OFF)
        else $error("Enables not all off in non-driving mode.");

    a_only_fields: assert property (
        $stable(ctrl_ff) [*2]
        |-> $stable(en_out))
        else $error("Enables changed with fields steady.");

    a_pullup_out: assert property (
        ##1 DPLUS_PULLUP_ENABLE_O == $past(pu_dec && !drivers_off))
        else $error("Pull-up enable does not follow its decode.");

    a_pullup_ls_off: assert property (
        transceiver_speed_select == UTD_SPEED_LS
        |=> !DPLUS_PULLUP_ENABLE_O)
        else $error("Pull-up enable on at low speed.");

    a_pullup_dp_excl: assert property (
        dplus_pulldown_ctl
        |=> !DPLUS_PULLUP_ENABLE_O)
        else $error("Pull-up enabled together with the D+ pull-down.");

    a_pulldown_out: assert property (
        !drivers_off
        |=> DPLUS_PULLDOWN_ENABLE_O == $past(dplus_pulldown_ctl)
            && DMINUS_PULLDOWN_ENABLE_O == $past(dminus_pulldown_ctl))
        else $error("Pull-down enables do not follow their controls.");

    a_hsterm_out: assert property (
        !drivers_off && termination_select
        |=> !HIGHSPEED_TERMINATION_ENABLE_O)
        else $error("HS termination on with FS termination selected.");

    a_hsterm_on: assert property (
        !drivers_off && !termination_select && transceiver_speed_select == UTD_SPEED_HS
        |=> HIGHSPEED_TERMINATION_ENABLE_O)
        else $error("HS termination off for an unterminated HS port.");

    // Signaling-state table rows.
    a_host_chirp_hs: assert property (
        fld(ctrl_ff, 2'h0, 1'b0, 2'h2, 1'b1, 1'b1) || fld(ctrl_ff, 2'h0, 1'b0, 2'h0, 1'b1, 1'b1)
        |=> en_out == UTD_EN_HOST_HS)
        else $error("Host chirp or HS decode wrong.");

    a_host_fs: assert property (
        fld(ctrl_ff, 2'h1, 1'b1, 2'h0, 1'b1, 1'b1) || fld(ctrl_ff, 2'h3, 1'b1, 2'h0, 1'b1, 1'b1)
        |=> en_out == UTD_EN_HOST)
        else $error("Host FS decode wrong.");

    a_host_fs_resume: assert property (
        fld(ctrl_ff, 2'h1, 1'b1, 2'h2, 1'b1, 1'b1)
        |=> en_out == UTD_EN_HOST)
        else $error("Host HS/FS resume decode wrong.");

    a_host_ls_susp: assert property (
        fld(ctrl_ff, 2'h2, 1'b1, 2'h0, 1'b1, 1'b1)
        |=> en_out == UTD_EN_HOST)
        else $error("Host LS suspend decode wrong.");

    a_host_ls_resume: assert property (
        fld(ctrl_ff, 2'h2, 1'b1, 2'h2, 1'b1, 1'b1)
        |=> en_out == UTD_EN_HOST)
        else $error("Host LS resume decode wrong.");

    a_host_test_jk: assert property (
        fld(ctrl_ff, 2'h0, 1'b0, 2'h2, 1'b1, 1'b1) ##1 1'b1
        |-> HIGHSPEED_TERMINATION_ENABLE_O && DPLUS_PULLDOWN_ENABLE_O && DMINUS_PULLDOWN_ENABLE_O)
        else $error("Host test J/K decode wrong.");

    a_peri_chirp: assert property (
        fld(ctrl_ff, 2'h0, 1'b1, 2'h2, 1'b0, 1'b0)
        |=> en_out == UTD_EN_PERI)
        else $error("Peripheral chirp decode wrong.");

    a_peri_hs: assert property (
        fld(ctrl_ff, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0) || fld(ctrl_ff, 2'h0, 1'b0, 2'h2, 1'b0, 1'b0)
        |=> en_out == UTD_EN_PERI_HS)
        else $error("Peripheral HS or test J/K decode wrong.");

    a_peri_fs: assert property (
        fld(ctrl_ff, 2'h1, 1'b1, 2'h0, 1'b0, 1'b0) || fld(ctrl_ff, 2'h1, 1'b1, 2'h2, 1'b0, 1'b0)
        |=> en_out == UTD_EN_PERI)
        else $error("Peripheral FS decode wrong.");

    a_otg_chirp: assert property (
        fld(ctrl_ff, 2'h0, 1'b1, 2'h2, 1'b0, 1'b1)
        |=> en_out == UTD_EN_OTG)
        else $error("OTG chirp decode wrong.");

    a_otg_hs: assert property (
        fld(ctrl_ff, 2'h0, 1'b0, 2'h0, 1'b0, 1'b1) || fld(ctrl_ff, 2'h0, 1'b0, 2'h2, 1'b0, 1'b1)
        |=> en_out == UTD_EN_OTG_HS)
        else $error("OTG HS or test J/K decode wrong.");

    a_otg_fs: assert property (
        fld(ctrl_ff, 2'h1, 1'b1, 2'h0, 1'b0, 1'b1) || fld(ctrl_ff, 2'h1, 1'b1, 2'h2, 1'b0, 1'b1)
        |=> en_out == UTD_EN_OTG)
        else $error("OTG FS decode wrong.");

    a_powerup_state: assert property (
        ctrl_ff == UTD_CTRL_RST
        |=> en_out == UTD_EN_RST)
        else $error("Power-up fields do not give the two pull-downs.");

endmodule

// ===== utd_pkg.sv
// Constants for the USB termination decode block: register map, field layout,
// reset values and the resistor-enable codes of the signaling states.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one word per register.
//
// Notes on behaviour
// - Resistor enables depend only on speed, termination, mode and both pull-down fields.
// - D+ pull-up enable high connects the 1.5 kOhm pull-up on D+.
// - Pull-down enables connect the 15 kOhm pull-downs on D- and D+.
// - High-speed termination enable connects 45 Ohm terminations on both lines together.
// - Mode 01b forces all four enables off whatever the other fields hold.
// - Host chirp and host high-speed: both pull-downs plus termination, pull-up off.
// - Host full-speed: only the two pull-down enables.
// - Host high/full-speed suspend and resume: only the two pull-down enables.
// - Host low-speed suspend: only the two pull-down enables.
// - Host low-speed resume: only the two pull-down enables.
// - Host test J or K: both pull-downs plus high-speed termination.
// - Peripheral chirp: only the D+ pull-up enable.
// - Peripheral high-speed and test J/K: only high-speed termination.
// - Peripheral full-speed, suspend and resume: only the D+ pull-up enable.
// - OTG peripheral chirp: D+ pull-up and D- pull-down enables.
// - OTG peripheral high-speed and test J/K: D- pull-down and termination enables.
// - OTG peripheral full-speed, suspend and resume: D+ pull-up and D- pull-down.

package utd_pkg;

    // Register byte offsets.
    localparam logic [3:0] UTD_CTRL_OFS   = 4'h0;
    localparam logic [3:0] UTD_STATUS_OFS = 4'h4;

    // Control register field positions.
    localparam int UTD_SPEED_LSB = 0;
    localparam int UTD_TERM_BIT  = 2;
    localparam int UTD_MODE_LSB  = 3;
    localparam int UTD_DPPD_BIT  = 5;
    localparam int UTD_DMPD_BIT  = 6;
    localparam int UTD_CTRL_W    = 7;

    // Control register reset value: speed 01b, termination 0, mode 00b, pull-downs 1.
    localparam logic [6:0] UTD_CTRL_RST = 7'h61;

    // Field encodings.
    localparam logic [1:0] UTD_SPEED_HS = 2'h0;
    localparam logic [1:0] UTD_SPEED_FS = 2'h1;
    localparam logic [1:0] UTD_SPEED_LS = 2'h2;
    localparam logic [1:0] UTD_MODE_NORMAL = 2'h0;
    localparam logic [1:0] UTD_MODE_NODRV  = 2'h1;
    localparam logic [1:0] UTD_MODE_NOSYNC = 2'h2;

    // Enable vector order: {pull-up D+, pull-down D+, pull-down D-, HS termination}.
    localparam int UTD_EN_PU   = 3;
    localparam int UTD_EN_DPPD = 2;
    localparam int UTD_EN_DMPD = 1;
    localparam int UTD_EN_HST  = 0;
    localparam logic [3:0] UTD_EN_OFF     = 4'h0;
    localparam logic [3:0] UTD_EN_HOST    = 4'h6;
    localparam logic [3:0] UTD_EN_HOST_HS = 4'h7;
    localparam logic [3:0] UTD_EN_PERI    = 4'h8;
    localparam logic [3:0] UTD_EN_PERI_HS = 4'h1;
    localparam logic [3:0] UTD_EN_OTG     = 4'hA;
    localparam logic [3:0] UTD_EN_OTG_HS  = 4'h3;
    localparam logic [3:0] UTD_EN_RST     = 4'h6;

    typedef logic [31:0] utd_word_t;

endpackage

// ===== utd_link_model.sv
// Link controller model: an Avalon-MM master that programs the transceiver fields.
// Assumes a slave that answers through waitrequest; a stall of 16 cycles or more sets hung_o.
`timescale 1ns/1ps

module utd_link_model (
    // Bus clock.
    input  wire logic               clk_i,
    // Avalon-MM master side.
    input  wire logic               waitrequest_i,
    input  wire utd_pkg::utd_word_t readdata_i,
    output logic [3:0]              address_o,
    output logic                    read_o,
    output logic                    write_o,
    output logic [3:0]              byteenable_o,
    output utd_pkg::utd_word_t      writedata_o,
    output logic                    hung_o
);
    import utd_pkg::*;

    initial begin
        address_o = 4'h0;
        read_o = 1'b0;
        write_o = 1'b0;
        byteenable_o = 4'h0;
        writedata_o = 32'h0;
        hung_o = 1'b0;
    end

    // The request is held until waitrequest is seen low, and released after that edge.
    task automatic xfer(input logic rd, input logic [3:0] adr, input utd_word_t wd, input logic [3:0] be,
                        output utd_word_t rdata);
        int n;
        @(posedge clk_i);
        address_o <= adr;
        read_o <= rd;
        write_o <= !rd;
        byteenable_o <= be;
        writedata_o <= wd;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_i !== 1'b0 && n < 16);
        rdata = readdata_i;
        if (waitrequest_i !== 1'b0) hung_o = 1'b1;
        read_o <= 1'b0;
        write_o <= 1'b0;
    endtask
endmodule

// ===== utd_termination_decode_tb.sv
// Testbench for the termination decode: programs every signaling state over Avalon-MM.
// Assumes one clock at 100 MHz and the link model in utd_link_model.sv.
`timescale 1ns/1ps

module utd_termination_decode_tb;
    import utd_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  adr, be;
    logic        rd, wr, wait_req, hung, pu, dppd, dmpd, hst;
    utd_word_t   wdata, rdata, rd_val;
    int          miscompares = 0;
    int          check_count = 0;
    // Each entry is {control field value, expected {pull-up, D+ pd, D- pd, HS term}}.
    logic [10:0] tab [0:20] = '{
        {7'h70, 4'h7}, {7'h60, 4'h7},
        {7'h65, 4'h6}, {7'h67, 4'h6}, {7'h75, 4'h6},
        {7'h66, 4'h6}, {7'h76, 4'h6},
        {7'h14, 4'h8}, {7'h05, 4'h8}, {7'h15, 4'h8},
        {7'h00, 4'h1}, {7'h10, 4'h1},
        {7'h54, 4'hA}, {7'h45, 4'hA}, {7'h55, 4'hA},
        {7'h40, 4'h3}, {7'h50, 4'h3},
        {7'h6F, 4'h0}, {7'h08, 4'h0}, {7'h2B, 4'h0},
        {7'h61, 4'h6}};

    always #5 clk = ~clk;

    utd_link_model link (.clk_i(clk), .waitrequest_i(wait_req), .readdata_i(rdata), .address_o(adr),
        .read_o(rd), .write_o(wr), .byteenable_o(be), .writedata_o(wdata), .hung_o(hung));

    utd_termination_decode dut (.CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wait_req), .DPLUS_PULLUP_ENABLE_O(pu), .DPLUS_PULLDOWN_ENABLE_O(dppd),
        .DMINUS_PULLDOWN_ENABLE_O(dmpd), .HIGHSPEED_TERMINATION_ENABLE_O(hst));

    task automatic chk(input string what, input utd_word_t exp, input utd_word_t got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 1000 cycles.
    initial begin
        #20000;
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (16) @(negedge clk);
        chk("enables in reset", 32'h6, {28'h0, pu, dppd, dmpd, hst});
        @(posedge clk);
        rstn <= 1'b1;
        link.xfer(1'b1, 4'h0, 32'h0, 4'hF, rd_val);
        chk("control after reset", 32'h61, rd_val);
        for (int i = 0; i < 21; i++) begin
            link.xfer(1'b0, 4'h0, {25'h0, tab[i][10:4]}, 4'hF, rd_val);
            @(posedge clk);
            @(negedge clk);
            chk("resistor enables", {28'h0, tab[i][3:0]}, {28'h0, pu, dppd, dmpd, hst});
            link.xfer(1'b1, 4'h4, 32'h0, 4'hF, rd_val);
            chk("status", {28'h0, tab[i][3:0]}, rd_val);
        end
        // Refused writes: status, disabled byte lane, unmapped offset.
        link.xfer(1'b0, 4'h4, 32'h7F, 4'hF, rd_val);
        link.xfer(1'b0, 4'h0, 32'h14, 4'h0, rd_val);
        link.xfer(1'b0, 4'h8, 32'h14, 4'hF, rd_val);
        link.xfer(1'b1, 4'h0, 32'h0, 4'hF, rd_val);
        chk("control kept", 32'h61, rd_val);
        link.xfer(1'b1, 4'h8, 32'h0, 4'hF, rd_val);
        chk("unmapped read", 32'h0, rd_val);
        chk("enables kept", 32'h6, {28'h0, pu, dppd, dmpd, hst});
        // Reset in mid-run brings back the power-up fields and enables.
        link.xfer(1'b0, 4'h0, 32'h14, 4'hF, rd_val);
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        chk("enables in mid reset", 32'h6, {28'h0, pu, dppd, dmpd, hst});
        @(posedge clk);
        rstn <= 1'b1;
        link.xfer(1'b1, 4'h0, 32'h0, 4'hF, rd_val);
        chk("control after mid reset", 32'h61, rd_val);
        chk("bus stall", 32'h0, {31'h0, hung});
        end_sim();
    end
endmodule
